// *** hw/cma_pkg.sv ***
// Purpose: Constants and carrier types for the core memory address map
// Assumes: 20 MHz core clock, single reset domain
// Notes:   Offsets are internal data addresses of the special registers
//
// Summary of operation
// R1: After reset the first instruction fetch is from program address 0000H.
// R2: Each interrupt source has a fixed vector, slots 8 bytes apart.
// R3: Above 7FH direct goes to special registers, indirect to upper RAM.
// R4: Upper 128-byte RAM answers indirect accesses only, never direct.
// R5: Lower 128 bytes reachable by both direct and indirect accesses.
// R6: Lowest 32 bytes are four banks of eight working registers.
// R7: 16 bytes above the banks are bit addressable as bits 00H-7FH.
// R8: Special registers at addresses ending 0H or 8H are bit addressable.
// R9: One-byte data addresses reach 384 bytes via direct/indirect split.
// R10: Machine cycle is two clocks; instructions take 1, 2 or 4 cycles.
// R11: Decoder accepts instructions of one, two or three bytes.
// R12: Program store moves accumulator to program RAM at pointer, increments.
// R13: External data accesses use the 16-bit data pointer as address.
// R14: Program counter is 16 bits and covers 64 kilobytes.
// R15: Extended areas reached through special registers, 8 bits at a time.
// R16: Two or four priority levels, up to 24 maskable sources.
// R17: Debug pins are inputs with pull-ups during reset.
// R18: Programmer on debug pins at power-on switches them to programming use.
// R19: Configuration option picks external reset or general port bit.
// R20: Bank select bits are cleared at reset, bank zero active.
package cma_pkg;
  localparam logic [15:0] RESET_PC      = 16'h0000;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam int          VEC_SPACING   = 8;
  localparam logic [7:0]  LOWER_TOP     = 8'h7F;
  localparam logic [7:0]  BANK_TOP      = 8'h1F;
  localparam logic [7:0]  BIT_AREA_BASE = 8'h20;
  localparam logic [7:0]  ADR_SP        = 8'h81;
  localparam logic [7:0]  ADR_DPL       = 8'h82;
  localparam logic [7:0]  ADR_DPH       = 8'h83;
  localparam logic [7:0]  ADR_SECOND_POINTER_LOW      = 8'h84;
  localparam logic [7:0]  ADR_SECOND_POINTER_HIGH      = 8'h85;
  localparam logic [7:0]  ADR_PSW       = 8'hD0;
  localparam logic [7:0]  ADR_ACC       = 8'hE0;
  localparam logic [7:0]  ADR_AUX       = 8'hF0;
  localparam logic [7:0]  RST_SP        = 8'h07;
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam int          PSW_RS_LSB    = 3;
  localparam int          CYC_PER_MC    = 2;
  localparam int          NUM_IRQ       = 24;

  // Access kind presented by the execution unit
  typedef enum logic [2:0]
  {
    CMA_OP_NONE   = 3'b000,
    CMA_OP_DIRECT = 3'b001,
    CMA_OP_INDIR  = 3'b010,
    CMA_OP_REG    = 3'b011,
    CMA_OP_BIT    = 3'b100,
    CMA_OP_PSTORE = 3'b101,
    CMA_OP_XDATA  = 3'b110,
    CMA_OP_IRQ    = 3'b111
  } cma_op_t;

  // One request from the execution unit
  typedef struct packed
  {
    cma_op_t     op;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [1:0]  len;
    logic [1:0]  mcycles;
  } cma_req_t;

  // Answer back to the execution unit
  typedef struct packed
  {
    logic        done;
    logic        err;
    logic [7:0]  rdata;
    logic [15:0] pc;
  } cma_rsp_t;

  // Program or external data memory strobe
  typedef struct packed
  {
    logic        en;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cma_ext_t;
endpackage

// *** hw/cma_ram.sv ***
// Purpose: Internal data RAM, registered read port
// Assumes: One access per cycle, read data gives the old contents during a write
// Notes:   Depth parameter covers lower and upper halves together
module cma_ram
#(
  parameter int DEPTH = 256,
  parameter int AW    = 8
)
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Read path; no reset so the array maps to block RAM
  always_comb
  begin
    rdata_next = mem[i_addr];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_addr] <= i_wdata;
    end
    rdata_reg <= rdata_next;
  end

  assign o_rdata = rdata_reg;
endmodule

// *** hw/cma_core_map.sv ***
// Purpose: Core address decode: RAM split, banks, bits, pointers, vectors
// Assumes: Execution unit holds a request stable until done
// Notes:   Each request runs whole machine cycles of two clocks each
module cma_core_map
#(
  parameter int NUM_IRQ = cma_pkg::NUM_IRQ
)
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset,
  input  wire logic              i_req_valid,
  input  wire cma_pkg::cma_req_t i_req,
  input  wire logic [4:0]        i_irq_id,
  input  wire logic [7:0]        i_xdata_rdata,
  input  wire logic              i_cfg_reset_pin,
  input  wire logic              i_port5_bit2_pin,
  input  wire logic              i_por,
  input  wire logic              i_debug_data_pin,
  input  wire logic              i_debug_clock_pin,
  output cma_pkg::cma_rsp_t      o_rsp,
  output cma_pkg::cma_ext_t      o_pmem,
  output cma_pkg::cma_ext_t      o_xdata,
  output logic                   o_ext_reset,
  output logic                   o_port5_bit2,
  output logic                   o_debug_pullup,
  output logic                   o_debug_oe,
  output logic                   o_isp_mode,
  output logic [1:0]             o_bank
);
  typedef enum logic [1:0]
  {
    CMA_ST_IDLE = 2'b00,
    CMA_ST_EXEC = 2'b01,
    CMA_ST_DONE = 2'b10
  } cma_state_t;

  // Direct space above 7FH is never RAM
  function automatic logic is_sfr(input cma_pkg::cma_op_t op,
                                  input logic [7:0] a);
    is_sfr = (op == cma_pkg::CMA_OP_DIRECT) && (a > cma_pkg::LOWER_TOP); // R3
  endfunction

  // Bit address to byte address
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    if (b <= cma_pkg::LOWER_TOP)
    begin
      bit_byte = cma_pkg::BIT_AREA_BASE + {4'h0, b[6:3]}; // R7
    end
    else
    begin
      bit_byte = {b[7:3], 3'b000}; // R8
    end
  endfunction

  cma_state_t  state_reg, state_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0]  sp_reg, sp_next;
  logic [15:0] data_pointer_reg, data_pointer_next;
  logic [15:0] dptr1_reg, dptr1_next;
  logic [7:0]  psw_reg, psw_next;
  logic [7:0]  acc_reg, acc_next;
  logic [7:0]  aux_reg, aux_next;
  cma_pkg::cma_rsp_t rsp_reg, rsp_next;
  cma_pkg::cma_ext_t pmem_reg, pmem_next;
  cma_pkg::cma_ext_t xd_reg, xd_next;
  logic        err_next;
  logic [7:0]  sfr_rd;
  logic [7:0]  ram_addr;
  logic        ram_we;
  logic [7:0]  ram_rdata;
  logic        ram_sel;
  logic [7:0]  bbyte;
  logic [2:0]  need;
  logic [2:0]  dbg_s1_reg, dbg_s2_reg, dbg_s3_reg;
  logic [2:0]  dbg_in;
  logic [2:0]  dbg_reg, dbg_next;
  logic        isp_reg, isp_next;
  logic        rst_o_reg, p52_reg;

  // Decode of data address; upper half only by indirect use
  always_comb
  begin
    bbyte   = bit_byte(i_req.addr);
    ram_sel = 1'b0;
    ram_addr = i_req.addr;
    if (i_req.op == cma_pkg::CMA_OP_REG)
    begin
      ram_addr = {3'b000, psw_reg[cma_pkg::PSW_RS_LSB +: 2],
                  i_req.addr[2:0]}; // R6
      ram_sel  = 1'b1;
    end
    else if (i_req.op == cma_pkg::CMA_OP_INDIR)
    begin
      ram_sel = 1'b1; // R4 R5
    end
    else if (i_req.op == cma_pkg::CMA_OP_DIRECT)
    begin
      ram_sel = !is_sfr(i_req.op, i_req.addr); // R5 R9
    end
    else if (i_req.op == cma_pkg::CMA_OP_BIT)
    begin
      ram_addr = bbyte;
      ram_sel  = (i_req.addr <= cma_pkg::LOWER_TOP);
    end
  end

  // Write on the last clock of the request only
  assign ram_we = ram_sel && i_req.wr && (state_reg == CMA_ST_EXEC) &&
                  (cnt_reg == need - 3'd1) &&
                  (i_req.op != cma_pkg::CMA_OP_BIT);

  cma_ram #(.DEPTH(256), .AW(8)) u_ram
  (
    .i_clk_sys (i_clk_sys),
    .i_we      (ram_we),
    .i_addr    (ram_addr),
    .i_wdata   (i_req.wdata),
    .o_rdata   (ram_rdata)
  );

  // Special register read mux; extended areas reached through these
  // Decoded byte address, so a bit op finds its owning register
  always_comb
  begin
    sfr_rd = 8'h00; // R15
    if (ram_addr == cma_pkg::ADR_SP)        sfr_rd = sp_reg;
    else if (ram_addr == cma_pkg::ADR_DPL)  sfr_rd = data_pointer_reg[7:0];
    else if (ram_addr == cma_pkg::ADR_DPH)  sfr_rd = data_pointer_reg[15:8];
    else if (ram_addr == cma_pkg::ADR_SECOND_POINTER_LOW) sfr_rd = dptr1_reg[7:0];
    else if (ram_addr == cma_pkg::ADR_SECOND_POINTER_HIGH) sfr_rd = dptr1_reg[15:8];
    else if (ram_addr == cma_pkg::ADR_PSW)  sfr_rd = psw_reg;
    else if (ram_addr == cma_pkg::ADR_ACC)  sfr_rd = acc_reg; // R8
    else if (ram_addr == cma_pkg::ADR_AUX)  sfr_rd = aux_reg;
  end

  // Clocks per request: machine cycles times two
  always_comb
  begin
    case (i_req.mcycles)
      2'd0:    need = 3'd2; // R10
      2'd1:    need = 3'd4; // R10
      default: need = 3'd0; // R10 four cycles wrap to eight clocks
    endcase
  end

  // Sequencer and architectural registers
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pc_next    = pc_reg;
    sp_next    = sp_reg;
    data_pointer_next  = data_pointer_reg;
    dptr1_next = dptr1_reg;
    psw_next   = psw_reg;
    acc_next   = acc_reg;
    aux_next   = aux_reg;
    rsp_next   = rsp_reg;
    pmem_next  = '0;
    xd_next    = '0;
    err_next   = 1'b0;
    rsp_next.done = 1'b0;
    case (state_reg)
      CMA_ST_IDLE:
      begin
        if (i_req_valid)
        begin
          state_next = CMA_ST_EXEC;
          cnt_next   = 3'd0;
        end
      end
      CMA_ST_EXEC:
      begin
        cnt_next = cnt_reg + 3'd1;
        if (cnt_reg == need - 3'd1)
        begin
          state_next = CMA_ST_DONE;
          // Length field of zero is refused, as is an interrupt number of NUM_IRQ or more
          err_next = (i_req.len == 2'd0) ||
                     (i_req.op == cma_pkg::CMA_OP_IRQ &&
                      i_irq_id >= 5'(NUM_IRQ)); // R11 R16
          rsp_next.err = err_next; // Stands until the next completion
          if (!err_next)
          begin
            pc_next = pc_reg + 16'(i_req.len); // R11 R14
          end
          rsp_next.rdata = ram_sel ? ram_rdata : sfr_rd;
          if (i_req.op == cma_pkg::CMA_OP_BIT)
          begin
            rsp_next.rdata = {7'h00, rsp_next.rdata[i_req.addr[2:0]]}; // R7
          end
          if (i_req.op == cma_pkg::CMA_OP_IRQ && !err_next)
          begin
            pc_next = cma_pkg::VEC_BASE +
                      16'(i_irq_id) * 16'(cma_pkg::VEC_SPACING); // R2
          end
          if (i_req.op == cma_pkg::CMA_OP_PSTORE)
          begin
            pmem_next = '{en: 1'b1, wr: 1'b1, addr: data_pointer_reg,
                          wdata: acc_reg}; // R12
            data_pointer_next = data_pointer_reg + 16'h0001; // R12
          end
          if (i_req.op == cma_pkg::CMA_OP_XDATA)
          begin
            xd_next = '{en: 1'b1, wr: i_req.wr, addr: data_pointer_reg,
                        wdata: i_req.wdata}; // R13
          end
          if (i_req.wr && is_sfr(i_req.op, i_req.addr))
          begin
            if (i_req.addr == cma_pkg::ADR_SP)
              sp_next = i_req.wdata;
            else if (i_req.addr == cma_pkg::ADR_DPL)
              data_pointer_next[7:0] = i_req.wdata;
            else if (i_req.addr == cma_pkg::ADR_DPH)
              data_pointer_next[15:8] = i_req.wdata;
            else if (i_req.addr == cma_pkg::ADR_SECOND_POINTER_LOW)
              dptr1_next[7:0] = i_req.wdata;
            else if (i_req.addr == cma_pkg::ADR_SECOND_POINTER_HIGH)
              dptr1_next[15:8] = i_req.wdata;
            else if (i_req.addr == cma_pkg::ADR_PSW)
              psw_next = i_req.wdata;
            else if (i_req.addr == cma_pkg::ADR_ACC)
              acc_next = i_req.wdata;
            else if (i_req.addr == cma_pkg::ADR_AUX)
              aux_next = i_req.wdata;
          end
        end
      end
      CMA_ST_DONE:
      begin
        rsp_next.done = 1'b1;
        state_next    = CMA_ST_IDLE;
      end
      default:
      begin
        state_next = CMA_ST_IDLE;
      end
    endcase
    rsp_next.pc  = pc_next;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg <= CMA_ST_IDLE;
      cnt_reg   <= 3'd0;
      pc_reg    <= cma_pkg::RESET_PC; // R1
      sp_reg    <= cma_pkg::RST_SP;
      data_pointer_reg  <= 16'h0000;
      dptr1_reg <= 16'h0000;
      psw_reg   <= cma_pkg::RST_ZERO; // R20
      acc_reg   <= cma_pkg::RST_ZERO;
      aux_reg   <= cma_pkg::RST_ZERO;
      rsp_reg   <= '0;
      pmem_reg  <= '0;
      xd_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pc_reg    <= pc_next;
      sp_reg    <= sp_next;
      data_pointer_reg  <= data_pointer_next;
      dptr1_reg <= dptr1_next;
      psw_reg   <= psw_next;
      acc_reg   <= acc_next;
      aux_reg   <= aux_next;
      rsp_reg   <= rsp_next;
      pmem_reg  <= pmem_next;
      xd_reg    <= xd_next;
    end
  end

  // Pin synchronisers: stage one feeds stage two only
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      // Idle high like the pulled-up pins, so no false low after reset
      dbg_s1_reg <= 3'b111;
      dbg_s2_reg <= 3'b111;
      dbg_s3_reg <= 3'b111;
    end
    else
    begin
      dbg_s1_reg <= {i_debug_data_pin, i_debug_clock_pin, i_port5_bit2_pin};
      dbg_s2_reg <= dbg_s1_reg;
      dbg_s3_reg <= dbg_s2_reg;
    end
  end

  // Accept a change once the last two stages agree
  always_comb
  begin
    dbg_in   = dbg_s2_reg;
    dbg_next = dbg_reg;
    for (int i = 0; i < 3; i++)
    begin
      if (dbg_s2_reg[i] == dbg_s3_reg[i])
      begin
        dbg_next[i] = dbg_in[i];
      end
    end
    // Programmer seen only while power-on reset is asserted
    isp_next = isp_reg;
    if (i_por)
    begin
      isp_next = (dbg_next[2:1] == 2'b00); // R18 programmer holds both low
    end
  end

  // Reset-time pin state; pull-ups on, drivers off while in reset
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      dbg_reg        <= 3'b111;
      isp_reg        <= 1'b0;
      o_debug_pullup <= 1'b1; // R17
      o_debug_oe     <= 1'b0; // R17
      rst_o_reg      <= 1'b0;
      p52_reg        <= 1'b0;
      o_bank         <= 2'b00; // R20
    end
    else
    begin
      dbg_reg        <= dbg_next;
      isp_reg        <= isp_next;
      o_debug_pullup <= i_por; // R17
      o_debug_oe     <= 1'b0;
      rst_o_reg      <= i_cfg_reset_pin && !dbg_next[0]; // R19
      p52_reg        <= i_cfg_reset_pin ? 1'b0 : dbg_next[0]; // R19
      o_bank         <= psw_next[cma_pkg::PSW_RS_LSB +: 2]; // R6
    end
  end

  assign o_rsp        = rsp_reg;
  assign o_pmem       = pmem_reg;
  assign o_xdata      = xd_reg;
  assign o_ext_reset  = rst_o_reg;
  assign o_port5_bit2 = p52_reg;
  assign o_isp_mode   = isp_reg;
endmodule

// *** test/cma_mem_model.sv ***
// Purpose: Program RAM and external data memory seen by the map block
// Assumes: Strobes last one clock, address and data valid with them
// Notes:   Keeps only what the bench needs to inspect afterwards
module cma_mem_model
(
  input  wire logic              i_clk_sys,
  input  wire cma_pkg::cma_ext_t i_pmem,
  input  wire cma_pkg::cma_ext_t i_xdata,
  output logic [7:0]             o_rdata,
  output logic [15:0]            o_pm_addr,
  output logic [7:0]             o_pm_data,
  output logic [15:0]            o_xd_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] xmem [0:255];

  // Byte-wide stores; read data toggles when idle so stale data shows
  always_ff @(posedge i_clk_sys)
  begin
    if (i_pmem.en && i_pmem.wr)
    begin
      o_pm_addr <= i_pmem.addr;
      o_pm_data <= i_pmem.wdata;
    end
    if (i_xdata.en)
    begin
      o_xd_addr <= i_xdata.addr;
      if (i_xdata.wr)
        xmem[i_xdata.addr[7:0]] <= i_xdata.wdata;
      o_rdata <= xmem[i_xdata.addr[7:0]];
    end
    else
      o_rdata <= ~o_rdata;
  end
endmodule

// *** test/cma_core_map_monitor.sv ***
// Purpose: Port-level timing checks of the core map
// Assumes: One clock domain, async active-high reset
// Notes:   Requests start from idle, so a rising valid marks a take
module cma_core_map_monitor
(
  input wire logic              i_clk_sys,
  input wire logic              i_reset,
  input wire logic              i_req_valid,
  input wire cma_pkg::cma_req_t i_req,
  input wire logic [4:0]        i_irq_id,
  input wire logic              i_cfg_reset_pin,
  input wire logic              i_por,
  input wire cma_pkg::cma_rsp_t o_rsp,
  input wire cma_pkg::cma_ext_t o_pmem,
  input wire cma_pkg::cma_ext_t o_xdata,
  input wire logic              o_port5_bit2,
  input wire logic              o_debug_pullup,
  input wire logic [1:0]        o_bank
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // Request taken with a given machine cycle code
  sequence s_take(m);
    $rose(i_req_valid) && i_req.mcycles == m;
  endsequence
  // Completion right after a strobe, strobe gone
  sequence s_finish;
    ##1 (o_rsp.done && !o_pmem.en && !o_xdata.en);
  endsequence

  property p_done_mc1;
    s_take(0) |=> !o_rsp.done[*3] ##1 o_rsp.done;
  endproperty
  property p_done_mc2;
    s_take(1) |=> !o_rsp.done[*5] ##1 o_rsp.done;
  endproperty
  property p_done_mc4;
    $rose(i_req_valid) && i_req.mcycles[1]
      |-> ##2 !o_rsp.done[*8] ##1 o_rsp.done;
  endproperty
  property p_done_pulse;
    o_rsp.done |=> !o_rsp.done;
  endproperty
  property p_pstore;
    o_pmem.en |-> o_pmem.wr and s_finish;
  endproperty
  property p_xdata;
    o_xdata.en |-> s_finish;
  endproperty
  property p_bank;
    $changed(o_bank) |=> o_rsp.done;
  endproperty
  property p_port_gate;
    i_cfg_reset_pin |=> !o_port5_bit2;
  endproperty
  property p_irq_vec;
    s_take(0) ##0 (i_req.op == cma_pkg::CMA_OP_IRQ && i_irq_id == 5'h01)
      |=> ##3 o_rsp.pc == 16'h000B;
  endproperty
  property p_pullup;
    i_por |=> o_debug_pullup;
  endproperty

  a_done_mc1: assert property (p_done_mc1)
    else $error("done not 3 clocks after take");
  a_done_mc2: assert property (p_done_mc2)
    else $error("done not 5 clocks after take");
  a_done_mc4: assert property (p_done_mc4)
    else $error("done not 9 clocks after take");
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one clock");
  a_pstore: assert property (p_pstore)
    else $error("program store strobe malformed");
  a_xdata: assert property (p_xdata)
    else $error("external data strobe malformed");
  a_bank: assert property (p_bank)
    else $error("bank moved outside a request");
  a_port_gate: assert property (p_port_gate)
    else $error("port bit live while pin is reset");
  a_irq_vec: assert property (p_irq_vec)
    else $error("vector one not at 000B");
  a_pullup: assert property (p_pullup)
    else $error("pull-up off during power-on");
endmodule

bind cma_core_map cma_core_map_monitor u_mon
(
  .i_clk_sys      (i_clk_sys),
  .i_reset        (i_reset),
  .i_req_valid    (i_req_valid),
  .i_req          (i_req),
  .i_irq_id       (i_irq_id),
  .i_cfg_reset_pin(i_cfg_reset_pin),
  .i_por          (i_por),
  .o_rsp          (o_rsp),
  .o_pmem         (o_pmem),
  .o_xdata        (o_xdata),
  .o_port5_bit2   (o_port5_bit2),
  .o_debug_pullup (o_debug_pullup),
  .o_bank         (o_bank)
);

// *** test/tb_top.sv ***
// Purpose: Directed checks of the core address map
// Assumes: Inputs change on the falling edge, one request at a time
// Notes:   Request held until done, then dropped for one idle clock
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, valid = 0, cfg = 0, p52 = 1;
  logic por = 1, dd = 1, dc = 1, ext, p5o, pull, oe, isp;
  logic [4:0] irq = 0;
  logic [1:0] bank;
  logic [7:0] xrd, pm_d, rd;
  logic [15:0] pm_a, xd_a, pc = 0;
  cma_pkg::cma_req_t req = '0;
  cma_pkg::cma_rsp_t rsp;
  cma_pkg::cma_ext_t pmem, xdata;
  int n_errors = 0, checks = 0, cyc, ticks = 0;

  cma_core_map u_dut (.i_clk_sys(clk), .i_reset(rst), .i_req_valid(valid),
    .i_req(req), .i_irq_id(irq), .i_xdata_rdata(xrd),
    .i_cfg_reset_pin(cfg), .i_port5_bit2_pin(p52), .i_por(por),
    .i_debug_data_pin(dd), .i_debug_clock_pin(dc), .o_rsp(rsp),
    .o_pmem(pmem), .o_xdata(xdata), .o_ext_reset(ext),
    .o_port5_bit2(p5o), .o_debug_pullup(pull), .o_debug_oe(oe),
    .o_isp_mode(isp), .o_bank(bank));
  cma_mem_model u_mem (.i_clk_sys(clk), .i_pmem(pmem), .i_xdata(xdata),
    .o_rdata(xrd), .o_pm_addr(pm_a), .o_pm_data(pm_d), .o_xd_addr(xd_a));

  // 20 MHz core clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hang ends the run as a failure
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 4000)
    begin
      n_errors++;
      final_report();
    end
  end

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One request; bounded wait for done, count of clocks after take
  task automatic rq(input cma_pkg::cma_op_t op, input logic w,
    input logic [7:0] a, input logic [7:0] d, input logic [1:0] ln,
    input logic [1:0] mc, input logic [4:0] id);
    int n;
    @(negedge clk);
    req = '{op, w, a, d, ln, mc};
    irq = id;
    valid = 1;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rsp.done !== 1'b1 && n < 40);
    cmp(16'(rsp.done), 16'h0001);
    valid = 0;
    cyc = n - 1;
    rd = rsp.rdata;
    pc = rsp.pc;
  endtask

  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    rq(cma_pkg::CMA_OP_DIRECT, 1, a, d, 2'd2, 2'd0, 5'd0);
  endtask
  task automatic dr(input logic [7:0] a);
    rq(cma_pkg::CMA_OP_DIRECT, 0, a, 8'h00, 2'd2, 2'd0, 5'd0);
  endtask
  task automatic ir(input logic [7:0] a, input logic w, input logic [7:0] d);
    rq(cma_pkg::CMA_OP_INDIR, w, a, d, 2'd1, 2'd0, 5'd0);
  endtask

  task automatic t_reset();
    repeat (16) @(negedge clk);
    cmp(pull, 1);
    cmp(oe, 0);
    cmp(bank, 0);
    cmp(rsp.pc, 16'h0000);
    rst = 0;
    repeat (6) @(negedge clk);
    cmp(isp, 0);
    por = 0;
    dr(8'h81);
    cmp(rd, 8'h07);
    cmp(pc, 16'h0002);
    $display("done t_reset");
  endtask

  // Every length and machine cycle code
  task automatic t_timing();
    logic [15:0] e;
    e = pc;
    for (int l = 1; l < 4; l++)
      for (int m = 0; m < 4; m++)
      begin
        rq(cma_pkg::CMA_OP_DIRECT, 0, 8'h30, 8'h00, 2'(l), 2'(m), 5'd0);
        e = e + 16'(l);
        cmp(pc, e);
        cmp(16'(cyc), 16'((m == 0) ? 3 : (m == 1) ? 5 : 9));
      end
    rq(cma_pkg::CMA_OP_DIRECT, 0, 8'h30, 8'h00, 2'd0, 2'd0, 5'd0);
    cmp(rsp.err, 1);
    cmp(pc, e);
    $display("done t_timing");
  endtask

  task automatic t_split();
    dw(8'h45, 8'h5A);
    ir(8'h45, 0, 8'h00);
    cmp(rd, 8'h5A);
    ir(8'h90, 1, 8'hC3);
    dr(8'h90);
    cmp(rd, 8'h00);
    ir(8'h90, 0, 8'h00);
    cmp(rd, 8'hC3);
    dw(8'hD0, 8'h18);
    cmp(bank, 2'd3);
    rq(cma_pkg::CMA_OP_REG, 1, 8'h02, 8'hA7, 2'd1, 2'd0, 5'd0);
    dw(8'hD0, 8'h00);
    dr(8'h1A);
    cmp(rd, 8'hA7);
    dw(8'h21, 8'h04);
    rq(cma_pkg::CMA_OP_BIT, 0, 8'h0A, 8'h00, 2'd2, 2'd0, 5'd0);
    cmp(rd[0], 1);
    dw(8'hE0, 8'h02);
    rq(cma_pkg::CMA_OP_BIT, 0, 8'hE1, 8'h00, 2'd2, 2'd0, 5'd0);
    cmp(rd[0], 1);
    $display("done t_split");
  endtask

  task automatic t_irq();
    logic [15:0] e;
    rq(cma_pkg::CMA_OP_IRQ, 0, 8'h00, 8'h00, 2'd1, 2'd0, 5'd1);
    cmp(pc, 16'h000B);
    rq(cma_pkg::CMA_OP_IRQ, 0, 8'h00, 8'h00, 2'd1, 2'd0, 5'd23);
    cmp(pc, 16'h00BB);
    e = pc;
    rq(cma_pkg::CMA_OP_IRQ, 0, 8'h00, 8'h00, 2'd1, 2'd0, 5'd24);
    cmp(rsp.err, 1);
    cmp(pc, e);
    $display("done t_irq");
  endtask

  task automatic t_pstore();
    dw(8'h82, 8'hFF);
    dw(8'h83, 8'h12);
    dw(8'hE0, 8'h66);
    rq(cma_pkg::CMA_OP_PSTORE, 1, 8'h00, 8'h00, 2'd1, 2'd1, 5'd0);
    cmp(pm_a, 16'h12FF);
    cmp(pm_d, 8'h66);
    dr(8'h82);
    cmp(rd, 8'h00);
    dr(8'h83);
    cmp(rd, 8'h13);
    rq(cma_pkg::CMA_OP_XDATA, 1, 8'h00, 8'h77, 2'd1, 2'd1, 5'd0);
    cmp(xd_a, 16'h1300);
    $display("done t_pstore");
  endtask

  task automatic t_pins();
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk);
      cfg = k[1];
      p52 = k[0];
      repeat (6) @(negedge clk);
      cmp(p5o, cfg ? 1'b0 : p52);
      cmp(ext, cfg & ~p52);
    end
    cfg = 0;
    $display("done t_pins");
  endtask

  // Programmer holds both debug pins low across a power-on reset
  task automatic t_isp();
    @(negedge clk);
    rst = 1;
    por = 1;
    dd = 0;
    dc = 0;
    repeat (16) @(negedge clk);
    cmp(pull, 1);
    rst = 0;
    repeat (6) @(negedge clk);
    cmp(isp, 1);
    por = 0;
    dd = 1;
    dc = 1;
    repeat (6) @(negedge clk);
    cmp(pull, 0);
    $display("done t_isp");
  endtask

  initial
  begin
    t_reset();
    t_timing();
    t_split();
    t_irq();
    t_pstore();
    t_pins();
    t_isp();
    final_report();
  end
endmodule
